//--- pkg/bfp_pkg.sv
// constants, types and helpers for the dual-direction queue port block
package bfp_pkg;

  localparam int DW = 36;
  localparam int AW = 10;
  localparam int PW = AW + 1;
  localparam int DEPTH = 1 << AW;
  localparam logic [PW-1:0] CAP = 11'h400;

  // default thresholds picked by the threshold select at master reset
  localparam logic [PW-1:0] THR_8 = 11'h008;
  localparam logic [PW-1:0] THR_16 = 11'h010;
  localparam logic [PW-1:0] THR_64 = 11'h040;

  // register byte addresses, one 32-bit word apart
  localparam logic [4:0] OFS_A_LOW = 5'h00;
  localparam logic [4:0] OFS_B_LOW = 5'h04;
  localparam logic [4:0] OFS_A_HIGH = 5'h08;
  localparam logic [4:0] OFS_B_HIGH = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  typedef enum logic [1:0] {
    BFP_LONG,
    BFP_WORD,
    BFP_BYTE
  } bfp_width_t;

  typedef struct packed {
    logic [DW-1:0] data;
    logic vld;
    logic [1:0] idx;
  } bfp_head_t;

  typedef struct packed {
    logic big_end;
    logic fall_through_select;
    bfp_width_t bw;
    logic [PW-1:0] a_low;
    logic [PW-1:0] b_low;
    logic [PW-1:0] a_high;
    logic [PW-1:0] b_high;
    logic [PW-1:0] ab_wr;
    logic [PW-1:0] ab_rd;
    logic [PW-1:0] ba_wr;
    logic [PW-1:0] ba_rd;
    bfp_head_t ab_head;
    bfp_head_t ba_head;
    logic [DW-1:0] asm_data;
    logic [1:0] asm_idx;
    logic [DW-1:0] buf0;
    logic [DW-1:0] buf1;
    logic [1:0] buf_cnt;
    logic [DW-1:0] a_dout;
    logic [DW-1:0] b_dout;
    logic a_oe;
    logic b_oe;
    logic a_ir;
    logic a_or;
    logic a_ae;
    logic a_af;
    logic b_ir;
    logic b_or;
    logic b_ae;
    logic b_af;
    logic [31:0] rdata;
  } bfp_state_t;

  function automatic logic [PW-1:0] bfp_thr(input logic [1:0] sel);
    logic [PW-1:0] r;
    unique case (sel)
      2'h1: r = THR_16;
      2'h2: r = THR_64;
      default: r = THR_8;
    endcase
    return r;
  endfunction

  function automatic logic [1:0] bfp_last(input bfp_width_t bw);
    logic [1:0] r;
    unique case (bw)
      BFP_WORD: r = 2'h1;
      BFP_BYTE: r = 2'h3;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // position of piece idx inside the long word, honouring byte order
  function automatic logic [1:0] bfp_pos(input logic [1:0] idx, input bfp_width_t bw,
                                         input logic be);
    logic [1:0] r;
    r = be ? 2'(bfp_last(bw) - idx) : idx;
    return r;
  endfunction

  function automatic logic [DW-1:0] bfp_piece(input logic [DW-1:0] w, input logic [1:0] idx,
                                              input bfp_width_t bw, input logic be);
    logic [DW-1:0] r;
    logic [1:0] k;
    r = '0;
    k = bfp_pos(idx, bw, be);
    unique case (bw)
      BFP_WORD: r[17:0] = w[18*k +: 18];
      BFP_BYTE: r[8:0] = w[9*k +: 9];
      default: r = w;
    endcase
    return r;
  endfunction

  function automatic logic [DW-1:0] bfp_insert(input logic [DW-1:0] acc, input logic [DW-1:0] p,
                                               input logic [1:0] idx, input bfp_width_t bw,
                                               input logic be);
    logic [DW-1:0] r;
    logic [1:0] k;
    r = acc;
    k = bfp_pos(idx, bw, be);
    unique case (bw)
      BFP_WORD: r[18*k +: 18] = p[17:0];
      BFP_BYTE: r[9*k +: 9] = p[8:0];
      default: r = p;
    endcase
    return r;
  endfunction

endpackage

//--- rtl/bfp_top.sv
// dual-direction queue pair with bus matching, near flags and threshold registers
//
// Overview of operation
// - each port has a 36-bit data bus split into input, output and enable.
// - port A near-empty is low while b_to_a words are at or below its low threshold.
// - port B near-empty is low while a_to_b words are at or below its low threshold.
// - port A near-full is low while a_to_b free places are at most its high threshold.
// - port B near-full is low while b_to_a free places are at most its high threshold.
// - byte order pin high at reset: most significant piece goes first on port B.
// - byte order pin low at reset: least significant piece goes first on port B.
// - after reset the same pin picks timing: high standard, low fall-through.
// - width select high gives port B byte or word by size; low gives long word.
// - one running clock times every transfer on both ports.
// - all port flags change only on rising clock edges.
// - fall-through shows the first word without a read; later words need reads.
// - threshold select at reset loads default thresholds of 8, 16 or 64.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps

module bfp_top
  import bfp_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic order_and_timing_select,
  input wire logic width_match_select,
  input wire logic size_select,
  input wire logic [1:0] threshold_select,
  input wire logic port_a_en,
  input wire logic port_a_write,
  input wire logic [DW-1:0] port_a_data_in,
  output logic [DW-1:0] port_a_data_out,
  output logic port_a_data_oe,
  output logic port_a_full_or_input_ready,
  output logic port_a_empty_or_output_ready,
  output logic port_a_near_empty_flag,
  output logic port_a_near_full_flag,
  input wire logic port_b_en,
  input wire logic port_b_write,
  input wire logic [DW-1:0] port_b_data_in,
  output logic [DW-1:0] port_b_data_out,
  output logic port_b_data_oe,
  output logic port_b_full_or_input_ready,
  output logic port_b_empty_or_output_ready,
  output logic port_b_near_empty_flag,
  output logic port_b_near_full_flag,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  bfp_state_t q;
  bfp_state_t d;
  logic [DW-1:0] ab_mem [DEPTH];
  logic [DW-1:0] ba_mem [DEPTH];
  logic a_push;
  logic a_pop;
  logic b_take;
  logic b_done;
  logic b_put;
  logic ba_push;
  logic [DW-1:0] asm_word;
  logic [PW-1:0] ab_cnt;
  logic [PW-1:0] ba_cnt;
  logic [PW-1:0] ab_words;
  logic [PW-1:0] ba_words;
  logic [PW-1:0] ab_cnt_n;
  logic [PW-1:0] ba_cnt_n;
  logic [PW-1:0] ab_words_n;
  logic [PW-1:0] ba_words_n;

  always_comb begin
    d = q;
    asm_word = q.asm_data;
    // counts come from pointers of this single clock domain
    ab_cnt = PW'(q.ab_wr - q.ab_rd);
    ba_cnt = PW'(q.ba_wr - q.ba_rd);
    ab_words = PW'(ab_cnt + PW'(q.ab_head.vld));
    ba_words = PW'(ba_cnt + PW'(q.ba_head.vld));

    // port A writes into a_to_b while input ready was shown
    a_push = port_a_en && port_a_write && q.a_ir;
    d.ab_wr = PW'(q.ab_wr + PW'(a_push));

    // port A reads whole long words of b_to_a
    a_pop = port_a_en && !port_a_write && q.a_or;
    if ((a_pop || !q.ba_head.vld) && ba_cnt != '0) begin
      d.ba_head.data = ba_mem[q.ba_rd[AW-1:0]];
      d.ba_head.vld = 1'b1;
      d.ba_rd = PW'(q.ba_rd + 1'b1);
    end else if (a_pop) begin
      d.ba_head.vld = 1'b0;
    end

    // port B reads a_to_b one piece at a time
    b_take = port_b_en && !port_b_write && q.b_or;
    b_done = b_take && q.ab_head.idx == bfp_last(q.bw);
    if (b_take && !b_done) begin
      d.ab_head.idx = 2'(q.ab_head.idx + 1'b1);
    end
    if ((b_done || !q.ab_head.vld) && ab_cnt != '0) begin
      d.ab_head.data = ab_mem[q.ab_rd[AW-1:0]];
      d.ab_head.vld = 1'b1;
      d.ab_head.idx = 2'h0;
      d.ab_rd = PW'(q.ab_rd + 1'b1);
    end else if (b_done) begin
      d.ab_head.vld = 1'b0;
      d.ab_head.idx = 2'h0;
    end

    // two-entry buffer drains into b_to_a whenever the queue has room
    ba_push = q.buf_cnt != 2'h0 && ba_cnt != CAP;
    d.ba_wr = PW'(q.ba_wr + PW'(ba_push));
    if (ba_push) begin
      d.buf0 = q.buf1;
      d.buf_cnt = 2'(q.buf_cnt - 1'b1);
    end

    // port B writes pieces that are packed into a long word
    b_put = port_b_en && port_b_write && q.b_ir;
    if (b_put) begin
      asm_word = bfp_insert(q.asm_data, port_b_data_in, q.asm_idx, q.bw, q.big_end);
      d.asm_data = asm_word;
      if (q.asm_idx == bfp_last(q.bw)) begin
        d.asm_idx = 2'h0;
        if (d.buf_cnt == 2'h0) begin
          d.buf0 = asm_word;
        end else begin
          d.buf1 = asm_word;
        end
        d.buf_cnt = 2'(d.buf_cnt + 1'b1);
      end else begin
        d.asm_idx = 2'(q.asm_idx + 1'b1);
      end
    end

    // data outputs: fall-through shows the head without a read
    if (q.fall_through_select) begin
      d.a_dout = d.ba_head.data;
      d.b_dout = bfp_piece(d.ab_head.data, d.ab_head.idx, q.bw, q.big_end);
    end else begin
      if (a_pop) begin
        d.a_dout = q.ba_head.data;
      end
      if (b_take) begin
        d.b_dout = bfp_piece(q.ab_head.data, q.ab_head.idx, q.bw, q.big_end);
      end
    end
    d.a_oe = port_a_en && !port_a_write;
    d.b_oe = port_b_en && !port_b_write;

    // threshold registers
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_A_LOW: d.a_low = reg_wdata[PW-1:0];
        OFS_B_LOW: d.b_low = reg_wdata[PW-1:0];
        OFS_A_HIGH: d.a_high = reg_wdata[PW-1:0];
        OFS_B_HIGH: d.b_high = reg_wdata[PW-1:0];
        default: d.a_low = q.a_low;
      endcase
    end
    d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_A_LOW: d.rdata = 32'(q.a_low);
        OFS_B_LOW: d.rdata = 32'(q.b_low);
        OFS_A_HIGH: d.rdata = 32'(q.a_high);
        OFS_B_HIGH: d.rdata = 32'(q.b_high);
        OFS_STATUS: d.rdata = {10'h000, ab_words, ba_words};
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    // flags from the next state, so each flop matches its queue
    ab_cnt_n = PW'(d.ab_wr - d.ab_rd);
    ba_cnt_n = PW'(d.ba_wr - d.ba_rd);
    ab_words_n = PW'(ab_cnt_n + PW'(d.ab_head.vld));
    ba_words_n = PW'(ba_cnt_n + PW'(d.ba_head.vld));
    d.a_ir = ab_cnt_n != CAP;
    d.b_ir = d.buf_cnt != 2'h2;
    d.a_or = d.ba_head.vld;
    d.b_or = d.ab_head.vld;
    d.a_ae = !(ba_words_n <= d.a_low);
    d.b_ae = !(ab_words_n <= d.b_low);
    d.a_af = !(PW'(CAP - ab_cnt_n) <= d.a_high);
    d.b_af = !(PW'(CAP - ba_cnt_n) <= d.b_high);
    d.fall_through_select = !order_and_timing_select;

    // master reset captures order, width and default thresholds
    if (!resetn) begin
      d = '0;
      d.big_end = order_and_timing_select;
      d.bw = !width_match_select ? BFP_LONG : (size_select ? BFP_BYTE : BFP_WORD);
      d.a_low = bfp_thr(threshold_select);
      d.b_low = bfp_thr(threshold_select);
      d.a_high = bfp_thr(threshold_select);
      d.b_high = bfp_thr(threshold_select);
      d.a_ir = 1'b1;
      d.b_ir = 1'b1;
      d.a_af = 1'b1;
      d.b_af = 1'b1;
    end
  end

  // every register moves on the one running clock edge
  always_ff @(posedge core_clk) begin
    q <= d;
  end

  always_ff @(posedge core_clk) begin
    if (a_push) begin
      ab_mem[q.ab_wr[AW-1:0]] <= port_a_data_in;
    end
    if (ba_push) begin
      ba_mem[q.ba_wr[AW-1:0]] <= q.buf0;
    end
  end

  assign port_a_data_out = q.a_dout;
  assign port_a_data_oe = q.a_oe;
  assign port_a_full_or_input_ready = q.a_ir;
  assign port_a_empty_or_output_ready = q.a_or;
  assign port_a_near_empty_flag = q.a_ae;
  assign port_a_near_full_flag = q.a_af;
  assign port_b_data_out = q.b_dout;
  assign port_b_data_oe = q.b_oe;
  assign port_b_full_or_input_ready = q.b_ir;
  assign port_b_empty_or_output_ready = q.b_or;
  assign port_b_near_empty_flag = q.b_ae;
  assign port_b_near_full_flag = q.b_af;
  assign reg_rdata = q.rdata;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  property p_a_near_empty;
    q.a_ae == !(ba_words <= q.a_low);
  endproperty
  a_a_near_empty: assert property (p_a_near_empty) else $error("port A near-empty wrong");

  property p_b_near_empty;
    q.b_ae == !(ab_words <= q.b_low);
  endproperty
  a_b_near_empty: assert property (p_b_near_empty) else $error("port B near-empty wrong");

  property p_a_near_full;
    q.a_af == !(PW'(CAP - ab_cnt) <= q.a_high);
  endproperty
  a_a_near_full: assert property (p_a_near_full) else $error("port A near-full wrong");

  property p_b_near_full;
    q.b_af == !(PW'(CAP - ba_cnt) <= q.b_high);
  endproperty
  a_b_near_full: assert property (p_b_near_full) else $error("port B near-full wrong");

  property p_big_first;
    (!q.fall_through_select && q.big_end && q.bw == BFP_BYTE && b_take && q.ab_head.idx == 2'h0)
      |=> q.b_dout[8:0] == $past(q.ab_head.data[35:27]);
  endproperty
  a_big_first: assert property (p_big_first) else $error("big order first byte wrong");

  property p_little_first;
    (!q.fall_through_select && !q.big_end && q.bw == BFP_WORD && b_take && q.ab_head.idx == 2'h0)
      |=> q.b_dout[17:0] == $past(q.ab_head.data[17:0]);
  endproperty
  a_little_first: assert property (p_little_first) else $error("little first word wrong");

  property p_mode_pick;
    $past(resetn) |-> q.fall_through_select == !$past(order_and_timing_select);
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("timing mode not from pin");

  property p_long_word;
    (!q.fall_through_select && q.bw == BFP_LONG && b_take) |=> q.b_dout == $past(q.ab_head.data) ##1 1'b1;
  endproperty
  a_long_word: assert property (p_long_word) else $error("long word read mismatch");

  property p_fall_through;
    (q.fall_through_select && !q.ab_head.vld && ab_cnt != '0)
      |=> q.b_or && q.b_dout == bfp_piece(q.ab_head.data, 2'h0, q.bw, q.big_end);
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("first word did not fall");

  property p_default_thr;
    $rose(resetn) |-> q.a_low == bfp_thr($past(threshold_select)) && q.b_high == q.a_low;
  endproperty
  a_default_thr: assert property (p_default_thr) else $error("default threshold wrong");

  property p_thr_rest;
    $rose(resetn) |-> q.b_low == q.a_low && q.a_high == q.a_low;
  endproperty
  a_thr_rest: assert property (p_thr_rest)
    else $error("default thresholds differ");

  property p_a_near_empty_rise;
    (ba_push && !a_pop && !reg_wr && ba_words == q.a_low) |=> q.a_ae;
  endproperty
  a_a_near_empty_rise: assert property (p_a_near_empty_rise)
    else $error("port A near-empty stayed low");

  property p_b_near_empty_rise;
    (a_push && !b_done && !reg_wr && ab_words == q.b_low) |=> q.b_ae;
  endproperty
  a_b_near_empty_rise: assert property (p_b_near_empty_rise)
    else $error("port B near-empty stayed low");

  // push without a head load takes one free place away
  property p_a_near_full_fall;
    (a_push && q.ab_head.vld && !b_take && !reg_wr
      && PW'(CAP - ab_cnt) == PW'(q.a_high + 1'b1)) |=> !q.a_af;
  endproperty
  a_a_near_full_fall: assert property (p_a_near_full_fall)
    else $error("port A near-full stayed high");

  property p_order_pick;
    $rose(resetn) |-> q.big_end == $past(order_and_timing_select);
  endproperty
  a_order_pick: assert property (p_order_pick)
    else $error("byte order not from pin");

  property p_width_pick;
    $rose(resetn) |-> (q.bw == BFP_LONG) == !$past(width_match_select);
  endproperty
  a_width_pick: assert property (p_width_pick)
    else $error("bus width not from pin");

  property p_reset_flags;
    $rose(resetn) |-> q.a_ir && q.b_ir && q.a_af && q.b_af
      && !q.a_ae && !q.b_ae && !q.a_or && !q.b_or;
  endproperty
  a_reset_flags: assert property (p_reset_flags)
    else $error("flags wrong after reset");

  property p_a_oe;
    $past(resetn) |-> q.a_oe == ($past(port_a_en) && !$past(port_a_write));
  endproperty
  a_a_oe: assert property (p_a_oe)
    else $error("port A drive enable wrong");

  property p_b_oe;
    $past(resetn) |-> q.b_oe == ($past(port_b_en) && !$past(port_b_write));
  endproperty
  a_b_oe: assert property (p_b_oe)
    else $error("port B drive enable wrong");

  // a valid head stays on the outputs until it is read
  property p_fall_hold;
    (q.fall_through_select && q.ab_head.vld && !b_take) |=> $stable(q.b_dout);
  endproperty
  a_fall_hold: assert property (p_fall_hold)
    else $error("fall-through output moved without read");

endmodule

//--- tb/bfp_host_model.sv
// far-side host model: drives the configuration pins of the queue block
`timescale 1ns/10ps

module bfp_host_model
  import bfp_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic want_big,
  input wire logic want_fall_through_select,
  input wire logic want_bm,
  input wire logic want_byte,
  input wire logic [1:0] want_thr,
  output logic order_and_timing_select,
  output logic width_match_select,
  output logic size_select,
  output logic [1:0] threshold_select
);
  logic fall_through_select_q;
  logic bm_q;
  logic byte_q;
  logic [1:0] thr_q;

  // levels are taken only while reset is held, then kept steady
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fall_through_select_q <= want_fall_through_select;
      bm_q <= want_bm;
      byte_q <= want_byte;
      thr_q <= want_thr;
    end
  end

  // byte order during reset, timing mode after it (high is standard)
  assign order_and_timing_select = resetn ? !fall_through_select_q : want_big;
  assign width_match_select = resetn ? bm_q : want_bm;
  assign size_select = resetn ? byte_q : want_byte;
  assign threshold_select = resetn ? thr_q : want_thr;
endmodule

//--- tb/testbench.sv
// self-checking bench for the dual-direction queue port block
`timescale 1ns/10ps

module testbench;
  import bfp_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic want_big = 1'b0;
  logic want_fall_through_select = 1'b0;
  logic want_bm = 1'b0;
  logic want_byte = 1'b0;
  logic [1:0] want_thr = 2'h0;
  logic ots;
  logic wms;
  logic szs;
  logic [1:0] ths;
  logic a_en = 1'b0;
  logic a_wr = 1'b0;
  logic b_en = 1'b0;
  logic b_wr = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DW-1:0] a_din = '0;
  logic [DW-1:0] b_din = '0;
  logic [DW-1:0] a_dout;
  logic [DW-1:0] b_dout;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic a_ir, a_or, a_ae, a_af, b_ir, b_or, b_ae, b_af;
  logic a_oe;
  logic b_oe;
  int failures = 0;
  int num_checks = 0;

  always #10 core_clk = ~core_clk;

  bfp_host_model bfp_host_model_i (.core_clk(core_clk), .resetn(resetn), .want_big(want_big),
    .want_fall_through_select(want_fall_through_select), .want_bm(want_bm), .want_byte(want_byte), .want_thr(want_thr),
    .order_and_timing_select(ots), .width_match_select(wms), .size_select(szs),
    .threshold_select(ths));

  bfp_top bfp_top_i (.core_clk(core_clk), .resetn(resetn), .order_and_timing_select(ots),
    .width_match_select(wms), .size_select(szs), .threshold_select(ths),
    .port_a_en(a_en), .port_a_write(a_wr), .port_a_data_in(a_din), .port_a_data_out(a_dout),
    .port_a_data_oe(a_oe), .port_a_full_or_input_ready(a_ir),
    .port_a_empty_or_output_ready(a_or),
    .port_a_near_empty_flag(a_ae), .port_a_near_full_flag(a_af),
    .port_b_en(b_en), .port_b_write(b_wr), .port_b_data_in(b_din), .port_b_data_out(b_dout),
    .port_b_data_oe(b_oe), .port_b_full_or_input_ready(b_ir),
    .port_b_empty_or_output_ready(b_or),
    .port_b_near_empty_flag(b_ae), .port_b_near_full_flag(b_af),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic miss(input string what);
    failures++;
    $display("unexpected at %0t: %s", $time, what);
  endtask

  task automatic chk_data(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    num_checks++;
    if (got !== exp) miss($sformatf("data %h, wanted %h", got, exp));
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) miss($sformatf("flag %b, wanted %b", got, exp));
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) miss($sformatf("register %h, wanted %h", got, exp));
  endtask

  task automatic do_reset(input logic big, input logic fall_through_select, input logic bm, input logic byt,
                          input logic [1:0] thr);
    want_big <= big;
    want_fall_through_select <= fall_through_select;
    want_bm <= bm;
    want_byte <= byt;
    want_thr <= thr;
    resetn <= 1'b0;
    tick(16);
    resetn <= 1'b1;
    tick(1);
  endtask

  // one transfer on port a or b; reads leave time for the fall-through head
  task automatic port_op(input logic on_b, input logic wr, input logic [DW-1:0] d);
    if (on_b) begin
      b_en <= 1'b1;
      b_wr <= wr;
      b_din <= d;
    end else begin
      a_en <= 1'b1;
      a_wr <= wr;
      a_din <= d;
    end
    tick(1);
    if (!wr) chk_flag(on_b ? b_oe : a_oe, 1'b1);
    a_en <= 1'b0;
    b_en <= 1'b0;
    tick(wr ? 1 : 3);
    chk_flag(on_b ? b_oe : a_oe, 1'b0);
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask

  task automatic reg_check(input logic [4:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    chk_reg(reg_rdata, exp);
    tick(1);
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    summarize();
  end

  initial begin
    logic [DW-1:0] w;
    logic [DW-1:0] x;
    // reset state and default thresholds from the select code
    do_reset(1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
    chk_flag(a_ae, 1'b0);
    chk_flag(a_ir, 1'b1);
    chk_flag(b_ir, 1'b1);
    chk_flag(a_or, 1'b0);
    chk_flag(b_af, 1'b1);
    reg_check(OFS_A_LOW, 32'h0000_0040);
    reg_check(OFS_B_HIGH, 32'h0000_0040);
    reg_check(5'h14, 32'h0000_0000);
    // long-word a_to_b traffic in standard mode
    do_reset(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    reg_write(OFS_A_HIGH, 32'h0000_03f0);
    tick(2);
    chk_flag(a_af, 1'b1);
    for (int i = 0; i < 8; i++) port_op(1'b0, 1'b1, 36'h0_0000_0100 + 36'(i));
    tick(3);
    chk_flag(b_ae, 1'b0);
    for (int i = 8; i < 20; i++) port_op(1'b0, 1'b1, 36'h0_0000_0100 + 36'(i));
    tick(3);
    chk_flag(b_ae, 1'b1);
    chk_flag(a_af, 1'b0);
    chk_flag(b_or, 1'b1);
    chk_data(b_dout, 36'h0_0000_0000);
    port_op(1'b1, 1'b0, '0);
    chk_data(b_dout, 36'h0_0000_0100);
    port_op(1'b1, 1'b0, '0);
    chk_data(b_dout, 36'h0_0000_0101);
    // byte bus, big endian, fall-through
    w = 36'h9_8765_4321;
    do_reset(1'b1, 1'b1, 1'b1, 1'b1, 2'h0);
    port_op(1'b0, 1'b1, w);
    tick(4);
    chk_data(b_dout, {27'h0, w[35:27]});
    for (int k = 1; k < 4; k++) begin
      port_op(1'b1, 1'b0, '0);
      chk_data(b_dout, {27'h0, w[35-9*k -: 9]});
    end
    port_op(1'b1, 1'b0, '0);
    chk_flag(b_or, 1'b0);
    // word bus, little endian, b_to_a traffic and its flags
    x = 36'ha_bcde_f012;
    do_reset(1'b0, 1'b0, 1'b1, 1'b0, 2'h0);
    reg_write(OFS_A_LOW, 32'h0000_0000);
    reg_write(OFS_B_HIGH, 32'h0000_03ff);
    tick(2);
    chk_flag(a_ae, 1'b0);
    chk_flag(b_af, 1'b1);
    port_op(1'b1, 1'b1, {18'h0, x[17:0]});
    port_op(1'b1, 1'b1, {18'h0, x[35:18]});
    port_op(1'b1, 1'b1, {18'h0, ~x[17:0]});
    port_op(1'b1, 1'b1, {18'h0, ~x[35:18]});
    tick(4);
    chk_flag(a_ae, 1'b1);
    chk_flag(a_or, 1'b1);
    chk_flag(b_af, 1'b0);
    port_op(1'b0, 1'b0, '0);
    chk_data(a_dout, x);
    port_op(1'b0, 1'b0, '0);
    chk_data(a_dout, ~x);
    // word bus, little endian, a_to_b traffic in standard mode
    port_op(1'b0, 1'b1, x);
    port_op(1'b1, 1'b0, '0);
    chk_data(b_dout, {18'h0, x[17:0]});
    port_op(1'b1, 1'b0, '0);
    chk_data(b_dout, {18'h0, x[35:18]});
    summarize();
  end
endmodule
